// ### sll_pkg.sv
// sll_pkg: constants for the serial latch load and lock block
// assumes a single 25 MHz system clock domain
package sll_pkg;
   localparam int          CLK_MHZ        = 25;
   localparam int          WORD_W         = 24;
   localparam int          SEL_W          = 2;
   localparam int          SEL_LSB        = 0;
   localparam logic [1:0]  SEL_CONTROL    = 2'h0;
   localparam logic [1:0]  SEL_R_COUNTER  = 2'h1;
   localparam logic [1:0]  SEL_N_COUNTER  = 2'h2;
   localparam logic [1:0]  SEL_TEST       = 2'h3;
   localparam logic [23:0] LATCH_RESET    = 24'h000000;
   localparam int          LOCK_CNT_W     = 3;
   localparam logic [2:0]  LOCK_CYC_NORM  = 3'h3;
   localparam logic [2:0]  LOCK_CYC_PREC  = 3'h5;
   localparam int          PHASE_ERR_W    = 8;
   localparam int          LOCK_SET_NS    = 15;
   localparam int          LOCK_LOSS_NS   = 25;
   localparam int          DIV_W          = 5;
   localparam logic [4:0]  DIV_A_MIN      = 5'h02;
   localparam logic [1:0]  OUT_DIV_A      = 2'h0;
   localparam logic [1:0]  OUT_DIV_2A     = 2'h1;
   localparam logic [1:0]  OUT_SCALED_RF  = 2'h2;
   localparam logic [1:0]  OUT_SCALED_REF = 2'h3;
endpackage

// ### sll_div_if.sv
// sll_div_if: carries the divider settings and output between modules
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface sll_div_if;
   import sll_pkg::*;
   logic [DIV_W-1:0] div_a;
   logic             osc_tick;
   logic             div_a_out;
   logic             div_2a_out;
   modport ctrl (output div_a, output osc_tick, input div_a_out, input div_2a_out);
   modport div  (input div_a, input osc_tick, output div_a_out, output div_2a_out);
endinterface

// ### sll_divider.sv
// sll_divider: auxiliary divide-by-A and divide-by-2A stage
// assumes osc_tick marks one oscillator period per pulse on clk_sys
`timescale 1ns/1ps
module sll_divider
   import sll_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   sll_div_if.div   dif
);
   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] div_eff;

   // ----------------------------------------
   // period counter
   // ----------------------------------------
   // values below the minimum clamp to it so the output never sticks high
   assign div_eff = (dif.div_a < DIV_A_MIN) ? DIV_A_MIN : dif.div_a;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count <= '0;
      end else if (dif.osc_tick) begin
         if (count >= div_eff - 5'h01) begin
            count <= '0;
         end else begin
            count <= count + 5'h01;
         end
      end
   end

   // high for one period in every A
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dif.div_a_out <= 1'b0;
      end else if (dif.osc_tick) begin
         dif.div_a_out <= (count >= div_eff - 5'h01);
      end
   end

   // toggle on each A pulse gives 2A with 50 percent duty
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dif.div_2a_out <= 1'b0;
      end else if (dif.osc_tick && count >= div_eff - 5'h01) begin
         dif.div_2a_out <= ~dif.div_2a_out;
      end
   end
endmodule

// ### sll_top.sv
// sll_top: three-wire serial port, four latches, lock indicator, divided output
// assumes serial pins are asynchronous and far slower than clk_sys
// no reset pin exists on the part; rstn clears every latch to zero
`timescale 1ns/1ps
// Overview of operation
// - shift data on each rising serial clock
// - word arrives msb first, last two select
// - load strobe rise copies word into one latch
// - lock indicator high locked, low when lost
// - output picks div A, 2A, scaled rf, ref
// - select 00 ctrl,01 r,10 n,11 test
// - lock after 3 or 5 good cycles
// - divide A one-period pulse, 2A even duty
module sll_top
   import sll_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rstn,
   input  wire logic                   serial_clock,
   input  wire logic                   serial_data,
   input  wire logic                   latch_load_strobe,
   input  wire logic                   osc_tick,
   input  wire logic                   pd_cycle,
   input  wire logic [PHASE_ERR_W-1:0] phase_error_ns,
   input  wire logic                   lock_precision_select,
   input  wire logic [DIV_W-1:0]       div_a,
   input  wire logic [1:0]             out_select,
   input  wire logic                   scaled_rf,
   input  wire logic                   reference_input,
   output logic [WORD_W-1:0]           control_latch,
   output logic [WORD_W-1:0]           r_counter_latch,
   output logic [WORD_W-1:0]           n_counter_latch,
   output logic [WORD_W-1:0]           test_latch,
   output logic                        n_latch_updated,
   output logic                        lock_indicator,
   output logic                        divided_clock_output
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0]            sync1;
   logic [4:0]            sync2;
   logic                  sclk_prev;
   logic                  strobe_prev;
   logic [WORD_W-1:0]     shift_reg;
   logic [SEL_W-1:0]      latch_select;
   logic [2**SEL_W-1:0]   latch_write;
   logic [LOCK_CNT_W-1:0] good_count;
   logic [LOCK_CNT_W-1:0] need_count;
   logic                  sclk_rise;
   logic                  strobe_rise;
   logic                  next_divided;
   sll_div_if             dif();

   // two stages on every pin from outside the clock domain; a pin edge may
   // land anywhere in a cycle, so nothing reads the first stage directly
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {reference_input, scaled_rf, latch_load_strobe, serial_data, serial_clock};
         sync2 <= sync1;
      end
   end

   // edge history taken from the second stage only
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sclk_prev   <= 1'b0;
         strobe_prev <= 1'b0;
      end else begin
         sclk_prev   <= sync2[0];
         strobe_prev <= sync2[2];
      end
   end

   // history clears to the idle low level, so reset makes no false edge
   assign sclk_rise   = sync2[0] & ~sclk_prev;
   assign strobe_rise = sync2[2] & ~strobe_prev;

   // ----------------------------------------
   // shift register
   // ----------------------------------------
   // bits beyond twenty-four fall off the top; only the last word counts
   // data enters at bit 0 so the first bit ends at the msb
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         shift_reg <= '0;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[WORD_W-2:0], sync2[1]};
      end
   end

   // the last two bits shifted in pick the target
   // the select is read live, so a strobe must follow the final bit
   assign latch_select = shift_reg[SEL_LSB +: SEL_W];

   // ----------------------------------------
   // latches
   // ----------------------------------------
   // one write enable per latch; an exact decode of the select pair means
   // a strobe can never touch two latches at once
   for (genvar gi = 0; gi < 2**SEL_W; gi++) begin : g_write
      assign latch_write[gi] = strobe_rise && (latch_select == SEL_W'(gi));
   end

   // control latch; holds until a strobe targets it
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         control_latch <= LATCH_RESET;
      end else if (latch_write[SEL_CONTROL]) begin
         control_latch <= shift_reg;
      end
   end

   // r counter latch; shifting alone never reaches it
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         r_counter_latch <= LATCH_RESET;
      end else if (latch_write[SEL_R_COUNTER]) begin
         r_counter_latch <= shift_reg;
      end
   end

   // n counter latch
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         n_counter_latch <= LATCH_RESET;
      end else if (latch_write[SEL_N_COUNTER]) begin
         n_counter_latch <= shift_reg;
      end
   end

   // the test latch is stored like the others, so a stray write harms
   // nothing else; the host is expected to leave it alone
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         test_latch <= LATCH_RESET;
      end else if (latch_write[SEL_TEST]) begin
         test_latch <= shift_reg;
      end
   end

   // pulse lets band logic restart; relies on host write order
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         n_latch_updated <= 1'b0;
      end else begin
         n_latch_updated <= latch_write[SEL_N_COUNTER];
      end
   end

   // ----------------------------------------
   // lock detect
   // ----------------------------------------
   // precision asks for the longer run of good cycles
   assign need_count = lock_precision_select ? LOCK_CYC_PREC : LOCK_CYC_NORM;

   // counts consecutive good detector cycles; saturates at the longer need
   // so a precision change mid-run still sees the whole run
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         good_count <= '0;
      end else if (pd_cycle) begin
         if (phase_error_ns >= PHASE_ERR_W'(LOCK_SET_NS)) begin
            good_count <= '0;
         end else if (good_count < LOCK_CYC_PREC) begin
            good_count <= good_count + 3'h1;
         end
      end
   end

   // errors from fifteen to twenty-five restart the run but leave lock up
   // set on the needed run, clear only past the loss limit
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lock_indicator <= 1'b0;
      end else if (pd_cycle) begin
         if (phase_error_ns > PHASE_ERR_W'(LOCK_LOSS_NS)) begin
            lock_indicator <= 1'b0;
         end else if (phase_error_ns < PHASE_ERR_W'(LOCK_SET_NS)
                      && good_count + 3'h1 >= need_count) begin
            lock_indicator <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // divided output
   // ----------------------------------------
   // osc_tick stands in for the oscillator; the divider moves only on it
   assign dif.div_a    = div_a;
   assign dif.osc_tick = osc_tick;

   // A and 2A come from one shared period counter
   sll_divider sll_divider_inst (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .dif     (dif)
   );

   // output mux; scaled inputs lag their pins by three cycles
   always_comb begin
      case (out_select)
         OUT_DIV_A:      next_divided = dif.div_a_out;
         OUT_DIV_2A:     next_divided = dif.div_2a_out;
         OUT_SCALED_RF:  next_divided = sync2[3];
         OUT_SCALED_REF: next_divided = sync2[4];
         default:        next_divided = 1'b0;
      endcase
   end

   // registered so the pin never shows a glitch from the mux
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         divided_clock_output <= 1'b0;
      end else begin
         divided_clock_output <= next_divided;
      end
   end
endmodule

// ### sll_assertions.sv
// sll_assertions: port-level checks for sll_top
// assumes it is bound into sll_top; one clk_sys domain, rstn low resets
`timescale 1ns/1ps
module sll_assertions
   import sll_pkg::*;
(
   input wire logic                   clk_sys,
   input wire logic                   rstn,
   input wire logic                   latch_load_strobe,
   input wire logic                   pd_cycle,
   input wire logic [PHASE_ERR_W-1:0] phase_error_ns,
   input wire logic                   lock_precision_select,
   input wire logic [1:0]             out_select,
   input wire logic                   reference_input,
   input wire logic [WORD_W-1:0]      control_latch,
   input wire logic [WORD_W-1:0]      r_counter_latch,
   input wire logic [WORD_W-1:0]      n_counter_latch,
   input wire logic [WORD_W-1:0]      test_latch,
   input wire logic                   n_latch_updated,
   input wire logic                   lock_indicator,
   input wire logic                   divided_clock_output
);
   // ------------------------------
   // helper counters
   // ------------------------------
   logic       strobe_q;
   logic [2:0] since_strobe; // saturates, so a stale strobe never excuses a change
   logic [2:0] run;
   logic [2:0] need;
   assign need = lock_precision_select ? LOCK_CYC_PREC : LOCK_CYC_NORM;
   // cycles since the strobe pin rose
   always_ff @(posedge clk_sys) begin
      strobe_q <= latch_load_strobe;
      if (!rstn) since_strobe <= 3'h7;
      else if (latch_load_strobe && !strobe_q) since_strobe <= 3'h0;
      else if (since_strobe != 3'h7) since_strobe <= since_strobe + 3'h1;
   end
   // consecutive good detector cycles
   always_ff @(posedge clk_sys) begin
      if (!rstn || (pd_cycle && phase_error_ns >= 8'h0f)) run <= 3'h0;
      else if (pd_cycle && run != 3'h7) run <= run + 3'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_latch_hold: assert property (
      ($changed(control_latch) || $changed(r_counter_latch) || $changed(n_counter_latch)
       || $changed(test_latch)) |-> since_strobe <= 3'h5)
      else $error("latch moved without load");
   chk_one_latch: assert property ($onehot0({$changed(control_latch),
      $changed(r_counter_latch), $changed(n_counter_latch), $changed(test_latch)}))
      else $error("several latches loaded");
   chk_n_pulse: assert property ($changed(n_counter_latch) |-> n_latch_updated)
      else $error("n latch write without pulse");
   chk_lock_set: assert property (
      pd_cycle && phase_error_ns < 8'h0f && run >= need - 3'h1 |=> lock_indicator)
      else $error("lock not set");
   chk_lock_early: assert property ($rose(lock_indicator) |-> run >= need)
      else $error("lock set too early");
   chk_lock_loss: assert property (
      pd_cycle && phase_error_ns > 8'h19 |=> !lock_indicator)
      else $error("lock not cleared");
   chk_lock_keep: assert property (
      lock_indicator && !(pd_cycle && phase_error_ns > 8'h19) |=> lock_indicator)
      else $error("lock dropped");
   chk_mux_ref: assert property (
      (out_select == OUT_SCALED_REF && $stable(reference_input))[*6]
      |-> divided_clock_output == reference_input) else $error("reference not routed");
endmodule

// ### sll_host_model.sv
// sll_host_model: host that programs the three-wire port
// assumes the caller enters its task just after a falling clk_sys edge
`timescale 1ns/1ps
module sll_host_model (
   input  wire logic clk_sys,
   output logic      serial_clock,
   output logic      serial_data,
   output logic      latch_load_strobe
);
   // serial clock idles low between frames
   initial begin
      serial_clock = 1'b0;
      serial_data = 1'b0;
      latch_load_strobe = 1'b0;
   end
   // hc is the half period in clk_sys cycles; below 1 edges would be lost
   task automatic send(input logic [23:0] w, input int hc, input logic load);
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         repeat (hc) @(negedge clk_sys);
         serial_clock = 1'b1;
         repeat (hc) @(negedge clk_sys);
         serial_clock = 1'b0;
      end
      serial_data = ~w[0]; // released line shows no stale bit
      latch_load_strobe = load;
      repeat (hc) @(negedge clk_sys);
      latch_load_strobe = 1'b0;
      repeat (hc) @(negedge clk_sys);
   endtask
endmodule

// ### test_sll_top.sv
// test_sll_top: self-checking bench for sll_top
// assumes sll_host_model and sll_assertions compiled before it
`timescale 1ns/1ps
module test_sll_top;
   import sll_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn, pd_cycle, lock_precision_select, scaled_rf, reference_input;
   logic osc_tick = 1'b0;
   logic sck, sdat, strobe, n_up, lock_indicator, divided_clock_output;
   logic [7:0] phase_error_ns;
   logic [4:0] div_a;
   logic [1:0] out_select;
   logic [23:0] lat [4];
   int n_mismatch = 0;
   int check_count = 0;
   int n_pulses = 0;
   always #20 clk_sys = ~clk_sys;
   always @(negedge clk_sys) osc_tick <= ~osc_tick; // one tick per two cycles
   // counted on the falling edge, away from the launching rising edge, so the pulse is read where it has settled
   always @(negedge clk_sys) if (n_up === 1'b1) n_pulses++;
   sll_host_model host_inst (.clk_sys(clk_sys), .serial_clock(sck), .serial_data(sdat),
      .latch_load_strobe(strobe));
   sll_top sll_top_inst (.clk_sys(clk_sys), .rstn(rstn), .serial_clock(sck),
      .serial_data(sdat), .latch_load_strobe(strobe), .osc_tick(osc_tick), .pd_cycle(pd_cycle),
      .phase_error_ns(phase_error_ns), .lock_precision_select(lock_precision_select),
      .div_a(div_a), .out_select(out_select), .scaled_rf(scaled_rf),
      .reference_input(reference_input), .control_latch(lat[0]), .r_counter_latch(lat[1]),
      .n_counter_latch(lat[2]), .test_latch(lat[3]), .n_latch_updated(n_up),
      .lock_indicator(lock_indicator), .divided_clock_output(divided_clock_output));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // r, control, n, test, then a word shifted with no strobe
   task automatic t_load();
      logic [23:0] w [5] = '{24'h5a5a51, 24'h3c3c30, 24'h0f0f02, 24'ha5a5a7, 24'hffffff};
      logic [23:0] e [4] = '{24'h0, 24'h0, 24'h0, 24'h0};
      for (int i = 0; i < 5; i++) begin
         host_inst.send(w[i], 2 + i, i < 4);
         if (i < 4) e[w[i][1:0]] = w[i];
         for (int k = 0; k < 4; k++) check(lat[k], e[k]);
      end
      check(24'(n_pulses), 24'h1);
   endtask
   task automatic lk(input logic [7:0] err, input logic exp);
      pd_cycle = 1'b1;
      phase_error_ns = err;
      @(negedge clk_sys);
      pd_cycle = 1'b0;
      phase_error_ns = ~err;
      repeat (2) @(negedge clk_sys);
      check_bit(lock_indicator, exp);
   endtask
   // fifteen breaks a run; twenty-five holds lock, twenty-six drops it
   task automatic t_lock();
      lk(8'h0e, 1'b0);
      lk(8'h0f, 1'b0);
      lk(8'h00, 1'b0);
      lk(8'h05, 1'b0);
      lk(8'h0e, 1'b1);
      lk(8'h19, 1'b1);
      lk(8'h1a, 1'b0);
      lock_precision_select = 1'b1;
      for (int i = 0; i < 5; i++) lk(8'h01, i == 4);
   endtask
   // high-cycle count over 80 cycles, then the two routed inputs
   task automatic t_div();
      logic [23:0] hi;
      for (int a = 2; a <= 4; a += 2) begin
         for (int s = 0; s < 2; s++) begin
            div_a = 5'(a);
            out_select = 2'(s);
            repeat (40) @(negedge clk_sys);
            hi = 24'h0;
            repeat (80) @(negedge clk_sys) hi = hi + {23'h0, divided_clock_output};
            check(hi, s == 1 ? 24'h28 : 24'(80 / a));
         end
      end
      for (int v = 0; v < 4; v++) begin
         out_select = 2'(2 + v / 2);
         scaled_rf = v[0] ^ (v < 2 ? 1'b0 : 1'b1);
         reference_input = v[0] ^ (v < 2 ? 1'b1 : 1'b0);
         repeat (6) @(negedge clk_sys);
         check_bit(divided_clock_output, v[0]);
      end
   endtask
   initial begin
      rstn = 1'b0;
      pd_cycle = 1'b0;
      phase_error_ns = 8'h00;
      lock_precision_select = 1'b0;
      div_a = 5'h04;
      out_select = 2'h0;
      scaled_rf = 1'b0;
      reference_input = 1'b0;
      repeat (4) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (3) @(negedge clk_sys);
      t_load();
      t_lock();
      t_div();
      print_verdict();
   end
   // watchdog, roughly six and a half times the expected run
   initial begin
      #400us;
      n_mismatch++;
      print_verdict();
   end
endmodule
bind sll_top sll_assertions chk_inst (.clk_sys, .rstn, .latch_load_strobe, .pd_cycle,
   .phase_error_ns, .lock_precision_select, .out_select, .reference_input, .control_latch,
   .r_counter_latch, .n_counter_latch, .test_latch, .n_latch_updated, .lock_indicator,
   .divided_clock_output);
